// >>> hw/left_adc_mux_cfg.svh
// Register offsets, field positions, reset values and step timing for the left ADC input mux control.
`ifndef LEFT_ADC_MUX_CFG_SVH
`define LEFT_ADC_MUX_CFG_SVH
`define LAM_ADDR_W 8
`define LAM_OFS_LINE_ONE 8'h13
`define LAM_OFS_LINE_TWO 8'h14
`define LAM_CFG_SEL_BIT 7
`define LAM_LEVEL_HI 6
`define LAM_LEVEL_LO 3
`define LAM_POWER_BIT 2
`define LAM_BIAS_BIT 2
`define LAM_STEP_HI 1
`define LAM_STEP_LO 0
`define LAM_LEVEL_OFF 4'hF
`define LAM_LEVEL_MAX 4'h8
`define LAM_RST_LINE_ONE 8'h78
`define LAM_RST_LINE_TWO 8'h78
`define LAM_RSVD_MASK_TWO 8'hFC
`define LAM_STEP_EVERY_FS 2'h0
`define LAM_STEP_EVERY_TWO_FS 2'h1
`define LAM_ATTEN_STEP_TENTH_DB 15
`endif

// >>> hw/left_adc_mux_pkg.sv
// Types for the left ADC input mux control block.
package left_adc_mux_pkg;
  // Live state of one line input as seen by the analog mixer.
  typedef struct packed {
    logic attached;
    logic differential;
    logic [3:0] level;
  } input_path_s;
  typedef enum logic [1:0] {STEP_ONE_FS, STEP_TWO_FS, STEP_OFF} step_rate_e;
endpackage

// >>> hw/left_adc_input_mux_control.sv
// Two configuration registers steering line inputs into the left ADC gain mixer.
// Operation
// - Level codes 0 to 8 give 0 dB down to 12 dB in 1.5 dB steps.
// - Code 1111 detaches the input; any valid code attaches it automatically.
// - First register bit 2 powers the left ADC up when set; reset off.
// - First register bits 1:0 pick soft-step rate: per Fs, per two Fs, off.
// - Second register bit 7 selects differential input two; reset single-ended.
// - Second register bit 2 weakly biases unselected inputs to common mode.
// - Second register bits 1:0 are reserved, read zero, written zero.
// - First register bit 7 selects differential input one; reset single-ended.
//
// Implementation choice: the plain strobed port.
`include "left_adc_mux_cfg.svh"
module left_adc_input_mux_control (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [`LAM_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Sample-rate tick, one cycle per Fs.
  input wire logic sampleTick,
  // Analog control outputs.
  output left_adc_mux_pkg::input_path_s lineOnePath,
  output left_adc_mux_pkg::input_path_s lineTwoPath,
  output logic [7:0] lineOneAttenTenthDb,
  output logic [7:0] lineTwoAttenTenthDb,
  output logic adcPowerUp,
  output logic commonModeBias
);

  // Attenuation in tenths of a dB for a level code; 1.5 dB per code.
  function automatic logic [7:0] attenOf(input logic [3:0] code);
    attenOf = 8'(code * `LAM_ATTEN_STEP_TENTH_DB);
  endfunction

  // Move an applied code one step toward its target.
  function automatic logic [3:0] stepToward(input logic [3:0] cur, input logic [3:0] tgt);
    if (cur < tgt) begin
      stepToward = cur + 4'h1;
    end else if (cur > tgt) begin
      stepToward = cur - 4'h1;
    end else begin
      stepToward = cur;
    end
  endfunction

  logic [7:0] regOne_r;
  logic [7:0] regTwo_r;
  logic [3:0] appliedOne_r;
  logic [3:0] appliedTwo_r;
  logic halfTick_r;
  logic [7:0] rdData_r;

  // Address decode.
  wire logic hitOne = (regAddr == `LAM_OFS_LINE_ONE);
  wire logic hitTwo = (regAddr == `LAM_OFS_LINE_TWO);
  wire logic [3:0] tgtOne = regOne_r[`LAM_LEVEL_HI:`LAM_LEVEL_LO];
  wire logic [3:0] tgtTwo = regTwo_r[`LAM_LEVEL_HI:`LAM_LEVEL_LO];
  wire logic [1:0] stepSel = regOne_r[`LAM_STEP_HI:`LAM_STEP_LO];

  // Step rate decode; codes 10 and 11 disable stepping.
  wire left_adc_mux_pkg::step_rate_e stepRate = (stepSel == `LAM_STEP_EVERY_FS) ? left_adc_mux_pkg::STEP_ONE_FS :
    (stepSel == `LAM_STEP_EVERY_TWO_FS) ? left_adc_mux_pkg::STEP_TWO_FS : left_adc_mux_pkg::STEP_OFF;
  wire logic stepNow = sampleTick &&
    ((stepRate == left_adc_mux_pkg::STEP_ONE_FS) || (stepRate == left_adc_mux_pkg::STEP_TWO_FS && halfTick_r));
  wire logic stepOff = (stepRate == left_adc_mux_pkg::STEP_OFF);

  // Applied codes: detach, attach and any change with stepping off act at once; other gain changes walk.
  // A move out of or into the detached code is never walked, since the
  // mixer has no meaningful gain while the input is off.
  wire logic [3:0] appliedOneNxt = (stepOff || tgtOne == `LAM_LEVEL_OFF || appliedOne_r == `LAM_LEVEL_OFF) ? tgtOne :
    stepNow ? stepToward(appliedOne_r, tgtOne) : appliedOne_r;
  wire logic [3:0] appliedTwoNxt = (stepOff || tgtTwo == `LAM_LEVEL_OFF || appliedTwo_r == `LAM_LEVEL_OFF) ? tgtTwo :
    stepNow ? stepToward(appliedTwo_r, tgtTwo) : appliedTwo_r;

  // Read mux; reserved bits of the second register read zero.
  wire logic [7:0] rdNxt = !regRead ? 8'h00 : hitOne ? regOne_r :
    hitTwo ? (regTwo_r & `LAM_RSVD_MASK_TWO) : 8'h00;

  // Register writes; reserved bits of the second register never store.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regOne_r <= `LAM_RST_LINE_ONE;
      regTwo_r <= `LAM_RST_LINE_TWO;
    end else if (regWrite && hitOne) begin
      regOne_r <= regWrData;
    end else if (regWrite && hitTwo) begin
      regTwo_r <= regWrData & `LAM_RSVD_MASK_TWO;
    end
  end

  // Applied gain, divide-by-two phase and read data.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      appliedOne_r <= `LAM_LEVEL_OFF;
      appliedTwo_r <= `LAM_LEVEL_OFF;
      halfTick_r <= 1'b0;
      rdData_r <= 8'h00;
    end else begin
      appliedOne_r <= appliedOneNxt;
      appliedTwo_r <= appliedTwoNxt;
      halfTick_r <= sampleTick ? !halfTick_r : halfTick_r;
      rdData_r <= rdNxt;
    end
  end

  // Outputs toward the analog mixer.
  assign regRdData = rdData_r;
  assign lineOnePath = '{attached: (appliedOne_r != `LAM_LEVEL_OFF),
    differential: regOne_r[`LAM_CFG_SEL_BIT], level: appliedOne_r};
  assign lineTwoPath = '{attached: (appliedTwo_r != `LAM_LEVEL_OFF),
    differential: regTwo_r[`LAM_CFG_SEL_BIT], level: appliedTwo_r};
  assign lineOneAttenTenthDb = attenOf(appliedOne_r);
  assign lineTwoAttenTenthDb = attenOf(appliedTwo_r);
  assign adcPowerUp = regOne_r[`LAM_POWER_BIT];
  assign commonModeBias = regTwo_r[`LAM_BIAS_BIT];

endmodule // left_adc_input_mux_control

// >>> verif/left_adc_mux_properties.sv
// Port checks for the left ADC input mux control.
module mux_cfg_checker (
  // Clock, reset, register port and tick.
  input wire logic core_clk, rst_n, regWrite, regRead, sampleTick,
  input wire logic [7:0] regAddr, regWrData, regRdData, lineOneAttenTenthDb, lineTwoAttenTenthDb,
  // Mixer controls.
  input wire left_adc_mux_pkg::input_path_s lineOnePath, lineTwoPath,
  input wire logic adcPowerUp, commonModeBias
);
  timeunit 1ns;
  timeprecision 1ns;
  // The rate copy lets the step check skip immediate moves while stepping is off.
  wire wrOne = regWrite && regAddr == 8'h13;
  wire wrTwo = regWrite && regAddr == 8'h14;
  wire [3:0] lvl = lineOnePath.level;
  logic [1:0] rate_r;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) rate_r <= 2'h0;
    else if (wrOne) rate_r <= regWrData[1:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence readTwo; regRead && regAddr == 8'h14; endsequence
  sequence moveOne; $changed(lvl) && $past(lvl) != 4'hF && lvl != 4'hF && !$past(rate_r[1]); endsequence
  AST_RSVD: assert property (readTwo |=> regRdData[1:0] == 2'h0) else $error("reserved bits");
  AST_PWR: assert property (wrOne |=> adcPowerUp == $past(regWrData[2])) else $error("power bit");
  AST_BIAS: assert property (wrTwo |=> commonModeBias == $past(regWrData[2])) else $error("bias bit");
  AST_CFG_ONE: assert property (wrOne |=> lineOnePath.differential == $past(regWrData[7])) else $error("cfg one");
  AST_CFG_TWO: assert property (wrTwo |=> lineTwoPath.differential == $past(regWrData[7])) else $error("cfg two");
  AST_ATT: assert property (lineTwoAttenTenthDb == 8'(lineTwoPath.level) * 8'h0F) else $error("atten");
  AST_DET: assert property (lineOnePath.attached == (lvl != 4'hF)) else $error("attach");
  AST_STEP: assert property (moveOne |-> $past(sampleTick) && (lvl + 4'h1 == $past(lvl) || $past(lvl) + 4'h1 == lvl))
    else $error("step");
endmodule // mux_cfg_checker
bind left_adc_input_mux_control mux_cfg_checker u_chk (.*);

// >>> verif/left_adc_input_mux_control_tb.sv
// Directed bench for the left ADC input mux control.
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, v); end end
module left_adc_input_mux_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, rst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0, sampleTick = 1'h0, adcPowerUp, commonModeBias;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, lineOneAttenTenthDb, lineTwoAttenTenthDb;
  left_adc_mux_pkg::input_path_s lineOnePath, lineTwoPath;
  int fail_count = 0, check_count = 0;
  // A 100 ns period.
  always #50 core_clk = ~core_clk;
  left_adc_input_mux_control dut (.*);
  // Writes end two edges late: applied codes follow the register one cycle later, so checks see settled outputs.
  task wr(input logic [7:0] a, d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge core_clk) regWrite <= 1'h0;
    @(posedge core_clk);
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, e);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge core_clk) regRead <= 1'h0;
    @(negedge core_clk) `CHK("read", e, regRdData)
    @(posedge core_clk);
  endtask
  task tk;
    sampleTick <= 1'h1;
    @(posedge core_clk) sampleTick <= 1'h0;
    @(posedge core_clk);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset value of the first register, then field writes (reserved bits written zero), a read-back and an unmapped read.
  task fields;
    rd(8'h13, 8'h78);
    wr(8'h13, 8'h84);
    `CHK("one", 6'h30, lineOnePath)
    `CHK("pwr", 1'h1, adcPowerUp)
    `CHK("att1", 8'h00, lineOneAttenTenthDb)
    wr(8'h14, 8'hC4);
    rd(8'h14, 8'hC4);
    rd(8'h15, 8'h00);
    `CHK("two", 6'h38, lineTwoPath)
    `CHK("att", 8'h78, lineTwoAttenTenthDb)
    `CHK("bias", 1'h1, commonModeBias)
  endtask
  // Paced steps at each rate, then the two rates that apply at once.
  task steps;
    wr(8'h13, 8'h9C);
    `CHK("lvl", 4'h0, lineOnePath.level)
    tk;
    `CHK("lvl", 4'h1, lineOnePath.level)
    wr(8'h13, 8'h9D);
    tk;
    tk;
    `CHK("lvl", 4'h2, lineOnePath.level)
    wr(8'h13, 8'h9E);
    `CHK("lvl", 4'h3, lineOnePath.level)
    wr(8'h13, 8'hBF);
    `CHK("lvl", 4'h7, lineOnePath.level)
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'h1;
    fields;
    steps;
    give_verdict;
  end
  // The tests take well under a thousand cycles.
  initial begin
    #1000000;
    fail_count++;
    give_verdict;
  end
endmodule // left_adc_input_mux_control_tb
